// ==== rtl/msc_mode_ctrl.sv ====
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Write enable low: pins 1xx give modes 4-7
// - Write enable high: modes 10,11,14,15 allow flashing
// - Initial bus 16 bits mode 4, else 8
// - Expanded: any 16-bit area gives 16-bit bus
// - ROM off modes 4,5; single-chip blocks external
// - Addresses limited to 16 Mbytes
// - Readback bit7 one, bits6-3 zero, read-only
// - Readback bits2-0 latch pins on read
// - Interrupt mode field, 01 and 11 prohibited
// - Bit3 chooses NMI edge
// - Bit2 releases low strobe pin to port
// - Bit1 selects IRQ4-7 source port
// - Bit0 RAM enable, reset to one
// - Flash gate zero unmaps flash registers
// - Flash gate one maps flash window
// - Flash gate resets zero, bits7-4 zero
// - Non-flash parts: flash gate nonfunctional
//////////////////////////////////////////////////////////////////////////////
module msc_mode_ctrl #(
    parameter bit FLASH_VARIANT = 1'b1,
    parameter bit ROMLESS       = 1'b0,
    // Returned by the flash gate on non-flash parts; arbitrary value
    parameter logic [7:0] UNDEF_READ = 8'h00
) (
    input  wire logic                       mclk,
    input  wire logic                       nrst,
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic      [31:0]                hrdata,
    output logic                            hreadyout,
    output logic                            hresp,
    input  wire logic                       mode_pin_2,
    input  wire logic                       mode_pin_1,
    input  wire logic                       mode_pin_0,
    input  wire logic                       flash_write_enable_pin,
    input  wire logic                       hw_standby,
    input  wire logic                       area_16bit_any,
    input  wire logic [msc_pkg::ADDR_BITS-1:0] cpu_addr,
    output logic      [3:0]                 op_mode,
    output logic                            mode_valid,
    output logic                            flash_prog_allowed,
    output logic                            rom_enable,
    output logic                            external_allowed,
    output logic                            bus_16bit,
    output logic                            irq_ctrl_mode_hi,
    output logic                            irq_ctrl_mode_lo,
    output logic                            irq_mode_prohibited,
    output logic                            nmi_edge_select,
    output logic                            low_strobe_out_disable,
    output logic                            irq_pin_route_select,
    output logic                            onchip_ram_enable,
    output logic                            flash_regs_map_enable,
    output logic                            flash_regs_selected
);
    import msc_pkg::*;

    initial begin
        if (ROMLESS && FLASH_VARIANT) begin
            $error("ROM-less part cannot be a flash variant");
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    always_ff @(posedge mclk) begin
        pin_meta <= {flash_write_enable_pin, mode_pin_2, mode_pin_1,
                     mode_pin_0};
        pin_sync <= pin_meta;
    end

    //////////////////////////////////////////////////////////////////////////
    // Mode decode; relies on straps being legal and steady
    // Non-flash parts ignore the write enable strap
    wire wen_eff = FLASH_VARIANT & pin_sync[3];
    wire [3:0] next_mode = {wen_eff, pin_sync[2:0]};

    function automatic logic mode_legal(input logic [3:0] m);
        case (m)
            4'h4, 4'h5:             mode_legal = 1'b1;
            4'h6, 4'h7:             mode_legal = !ROMLESS;
            4'hA, 4'hB, 4'hE, 4'hF: mode_legal = FLASH_VARIANT;
            default:                mode_legal = 1'b0;
        endcase
    endfunction

    // Mode caught one cycle after reset release so pins have settled
    logic       mode_caught;
    logic [3:0] mode_q;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            mode_caught <= 1'b0;
            mode_q      <= 4'h0;
        end else if (!mode_caught) begin
            mode_caught <= 1'b1;
            mode_q      <= next_mode;
        end
    end

    // Single-chip modes 7, 11 and 15 all end in pins 11
    wire single_chip = mode_q[1] & mode_q[0];
    wire rom_off     = (mode_q == MSC_MODE_4) | (mode_q == MSC_MODE_5);
    wire expanded    = mode_valid & !single_chip;

    // Initial width: mode 4 starts 16-bit until areas say otherwise.
    // Bus controller supplies area_16bit_any, which for mode 4 is high
    // after reset since all areas default to 16-bit there.
    logic area_seen;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            area_seen <= 1'b0;
        // Wait for the caught mode, else reset gives a false change
        end else if (mode_caught &&
                     area_16bit_any != (mode_q == MSC_MODE_4)) begin
            area_seen <= 1'b1;
        end
    end
    wire init_16  = (mode_q == MSC_MODE_4);
    wire width_16 = area_seen ? area_16bit_any : init_16;

    assign op_mode            = mode_q;
    assign mode_valid         = mode_caught & mode_legal(mode_q);
    assign flash_prog_allowed = mode_valid & mode_q[3];
    assign rom_enable         = mode_valid & !rom_off;
    assign external_allowed   = expanded;
    assign bus_16bit          = expanded & width_16;

    //////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: registers at four times their index
    wire        req      = hsel & hready & htrans[1];
    wire [15:0] word_idx = haddr[17:2];
    wire        hit_sc   = word_idx == SYSCTL_IDX;
    wire        hit_mr   = word_idx == MODERB_IDX;
    wire        hit_fg   = word_idx == FLGATE_IDX;

    msc_state_t state;
    logic       wr_q;
    logic [2:0] sel_q;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state <= MSC_IDLE;
            wr_q  <= 1'b0;
            sel_q <= 3'b000;
        end else begin
            state <= req ? MSC_DATA : MSC_IDLE;
            wr_q  <= req & hwrite;
            sel_q <= req ? {hit_fg, hit_mr, hit_sc} : 3'b000;
        end
    end

    wire data_ph = (state == MSC_DATA);
    wire wr_sc   = data_ph & wr_q & sel_q[0];
    wire wr_fg   = data_ph & wr_q & sel_q[2] & FLASH_VARIANT;
    wire rd_mr   = req & !hwrite & hit_mr;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    //////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] system_control;
    logic [7:0] flash_register_gate;
    logic [2:0] mode_sense;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            system_control <= SYSCTL_RESET;
        end else if (wr_sc) begin
            system_control <= hwdata[7:0] & SYSCTL_WMASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst || hw_standby) begin
            flash_register_gate <= FLGATE_RESET;
        end else if (wr_fg) begin
            flash_register_gate <= hwdata[7:0] & FLGATE_WMASK;
        end
    end

    // Latched at the address phase of a read of the readback register
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            mode_sense <= 3'b000;
        end else if (rd_mr) begin
            mode_sense <= pin_sync[2:0];
        end
    end

    wire [7:0] mode_readback = MODERB_FIXED | {5'h00, mode_sense};
    wire [7:0] fg_read = FLASH_VARIANT ? flash_register_gate
                                       : UNDEF_READ;

    wire [7:0] rd_byte = sel_q[0] ? system_control :
                         sel_q[1] ? mode_readback  :
                         sel_q[2] ? fg_read        : 8'h00;

    logic [31:0] rdata_q;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= {24'h000000, rd_byte};
        end
    end
    assign hrdata = data_ph ? {24'h000000, rd_byte} : rdata_q;

    //////////////////////////////////////////////////////////////////////////
    // Control outputs
    assign irq_ctrl_mode_hi       = system_control[SC_IRQ_MODE_HI];
    assign irq_ctrl_mode_lo       = system_control[SC_IRQ_MODE_LO];
    assign irq_mode_prohibited    = system_control[SC_IRQ_MODE_LO];
    assign nmi_edge_select        = system_control[SC_NMI_EDGE];
    assign low_strobe_out_disable = system_control[SC_LOW_STROBE];
    assign irq_pin_route_select   = system_control[SC_IRQ_ROUTE];
    assign onchip_ram_enable      = system_control[SC_RAM_EN];
    assign flash_regs_map_enable  = flash_register_gate[FG_MAP_EN];

    // Address space is 24 bits wide by construction
    wire in_flash_win = (cpu_addr >= FLASH_WIN_LO)
                      & (cpu_addr <= FLASH_WIN_HI);
    assign flash_regs_selected = flash_regs_map_enable & in_flash_win;

    //////////////////////////////////////////////////////////////////////////
    // Checks
    AST_RAM_RESET: assert property (@(posedge mclk)
        !nrst |=> onchip_ram_enable)
        else $error("RAM enable not set after reset");
    AST_GATE_RESET: assert property (@(posedge mclk)
        !nrst |=> !flash_regs_map_enable)
        else $error("Flash gate not cleared by reset");
    AST_FG_MAP: assert property (@(posedge mclk) disable iff (!nrst)
        !flash_regs_map_enable |-> !flash_regs_selected)
        else $error("Flash window mapped while gate clear");
    AST_FG_HIT: assert property (@(posedge mclk) disable iff (!nrst)
        flash_regs_map_enable && cpu_addr == FLASH_WIN_HI
        |-> flash_regs_selected)
        else $error("Flash window not mapped");
    AST_RB_FIXED: assert property (@(posedge mclk) disable iff (!nrst)
        mode_readback[7:3] == 5'h10)
        else $error("Readback fixed bits wrong");
    AST_RB_LATCH: assert property (@(posedge mclk) disable iff (!nrst)
        rd_mr |=> mode_sense == $past(pin_sync[2:0]))
        else $error("Mode sense not latched on read");
    AST_BIT6: assert property (@(posedge mclk) disable iff (!nrst)
        !system_control[6])
        else $error("System control bit 6 set");
    AST_ROM: assert property (@(posedge mclk) disable iff (!nrst)
        mode_valid && mode_q[2:1] == 2'b10 |-> !rom_enable)
        else $error("ROM on in mode 4 or 5");
    AST_SINGLE: assert property (@(posedge mclk) disable iff (!nrst)
        mode_valid && mode_q[1] && mode_q[0] |-> !external_allowed)
        else $error("External access in single-chip mode");
    AST_WIDTH: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(mode_caught) && mode_valid ##1 !area_seen
        |-> bus_16bit == (mode_q == MSC_MODE_4))
        else $error("Initial bus width wrong");
    AST_FLASH: assert property (@(posedge mclk) disable iff (!nrst)
        flash_prog_allowed |-> mode_q[3] && FLASH_VARIANT)
        else $error("Flash programming in wrong mode");
    AST_MODE1: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(mode_caught) && !mode_q[3]
        |-> mode_q[2:0] == $past(pin_sync[2:0]))
        else $error("Mode decode wrong");

    //////////////////////////////////////////////////////////////////////////
    // Mode and bus width checks
    AST_MODE_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
        mode_caught |=> $stable(mode_q))
        else $error("Mode changed while running");
    AST_FLASH_ON: assert property (@(posedge mclk) disable iff (!nrst)
        mode_valid && mode_q[3] |-> flash_prog_allowed)
        else $error("Flash programming not allowed in flash mode");
    AST_EXT_WIDTH: assert property (@(posedge mclk) disable iff (!nrst)
        !external_allowed |-> !bus_16bit)
        else $error("Bus width set without external bus");
    AST_TRACK: assert property (@(posedge mclk) disable iff (!nrst)
        area_seen && external_allowed |-> bus_16bit == area_16bit_any)
        else $error("Bus width not following areas");
    AST_ROM_ON: assert property (@(posedge mclk) disable iff (!nrst)
        mode_valid && (mode_q[1] || mode_q[3]) |-> rom_enable)
        else $error("ROM off in a ROM mode");
    AST_EXT_ON: assert property (@(posedge mclk) disable iff (!nrst)
        mode_valid && !(mode_q[1] && mode_q[0]) |-> external_allowed)
        else $error("External access blocked in expanded mode");

    //////////////////////////////////////////////////////////////////////////
    // Register and bus checks
    AST_SC_WRITE: assert property (@(posedge mclk) disable iff (!nrst)
        wr_sc |=> system_control == ($past(hwdata[7:0]) & SYSCTL_WMASK))
        else $error("System control write lost");
    AST_NMI_EDGE: assert property (@(posedge mclk) disable iff (!nrst)
        wr_sc |=> nmi_edge_select == $past(hwdata[3]))
        else $error("NMI edge select not written");
    AST_LOW_STROBE: assert property (@(posedge mclk) disable iff (!nrst)
        wr_sc |=> low_strobe_out_disable == $past(hwdata[2]))
        else $error("Low strobe disable not written");
    AST_IRQ_ROUTE: assert property (@(posedge mclk) disable iff (!nrst)
        wr_sc |=> irq_pin_route_select == $past(hwdata[1]))
        else $error("IRQ route select not written");
    AST_RAM_KEEP: assert property (@(posedge mclk) disable iff (!nrst)
        !wr_sc |=> $stable(onchip_ram_enable))
        else $error("RAM enable changed without a write");
    AST_FG_WRITE: assert property (@(posedge mclk) disable iff (!nrst)
        wr_fg && !hw_standby
        |=> flash_register_gate == ($past(hwdata[7:0]) & FLGATE_WMASK))
        else $error("Flash gate write lost");
    AST_FG_ZERO: assert property (@(posedge mclk) disable iff (!nrst)
        flash_register_gate[7:4] == 4'h0)
        else $error("Flash gate upper bits set");
    AST_STANDBY: assert property (@(posedge mclk) disable iff (!nrst)
        hw_standby |=> flash_register_gate == FLGATE_RESET)
        else $error("Flash gate not cleared in standby");
    AST_NOFLASH: assert property (@(posedge mclk) disable iff (!nrst)
        !FLASH_VARIANT |-> !flash_regs_map_enable)
        else $error("Flash gate active on non-flash part");
    AST_GATE_RD: assert property (@(posedge mclk) disable iff (!nrst)
        data_ph && !wr_q && sel_q[2] |-> hrdata[7:0] == fg_read)
        else $error("Flash gate read wrong");
    AST_RB_READ: assert property (@(posedge mclk) disable iff (!nrst)
        data_ph && !wr_q && sel_q[1]
        |-> hrdata[7:0] == {5'h10, mode_sense})
        else $error("Readback data wrong");
    AST_SENSE_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
        !rd_mr |=> $stable(mode_sense))
        else $error("Mode sense changed without a read");
    AST_FG_SEL: assert property (@(posedge mclk) disable iff (!nrst)
        flash_regs_selected
        |-> cpu_addr >= FLASH_WIN_LO && cpu_addr <= FLASH_WIN_HI)
        else $error("Flash window selected outside range");
    AST_HRDATA_HI: assert property (@(posedge mclk) disable iff (!nrst)
        data_ph |-> hrdata[31:8] == 24'h000000)
        else $error("Upper read data not zero");
    AST_OKAY: assert property (@(posedge mclk) disable iff (!nrst)
        hreadyout && !hresp)
        else $error("Bus answer not ready and okay");
endmodule

// ==== rtl/msc_pkg.sv ====
package msc_pkg;
    // Register byte addresses (low 16 bits); none are multiples of four,
    // so these are indices and the bus byte address is four times each
    localparam logic [15:0] SYSCTL_IDX    = 16'hFF39;
    localparam logic [15:0] MODERB_IDX    = 16'hFF3B;
    localparam logic [15:0] FLGATE_IDX    = 16'hFF42;
    localparam logic [7:0]  SYSCTL_RESET  = 8'h01;
    localparam logic [7:0]  FLGATE_RESET  = 8'h00;
    localparam logic [7:0]  MODERB_FIXED  = 8'h80;
    // System control and flash gate field positions
    localparam int SC_IRQ_MODE_HI = 5;
    localparam int SC_IRQ_MODE_LO = 4;
    localparam int SC_NMI_EDGE    = 3;
    localparam int SC_LOW_STROBE  = 2;
    localparam int SC_IRQ_ROUTE   = 1;
    localparam int SC_RAM_EN      = 0;
    localparam int FG_MAP_EN      = 3;
    // Writable masks
    localparam logic [7:0] SYSCTL_WMASK = 8'hBF;
    localparam logic [7:0] FLGATE_WMASK = 8'h08;
    // Flash control register window (24-bit address)
    localparam logic [23:0] FLASH_WIN_LO = 24'h0FFFC8;
    localparam logic [23:0] FLASH_WIN_HI = 24'h0FFFCB;
    // Address space limit: 16 Mbytes
    localparam int ADDR_BITS = 24;
    // Operating mode codes
    typedef enum logic [3:0] {
        MSC_MODE_4  = 4'h4,
        MSC_MODE_5  = 4'h5,
        MSC_MODE_6  = 4'h6,
        MSC_MODE_7  = 4'h7,
        MSC_MODE_10 = 4'hA,
        MSC_MODE_11 = 4'hB,
        MSC_MODE_14 = 4'hE,
        MSC_MODE_15 = 4'hF
    } msc_mode_t;
    // Bus slave state
    typedef enum logic [1:0] {
        MSC_IDLE = 2'b01,
        MSC_DATA = 2'b10
    } msc_state_t;
endpackage

// ==== sim/msc_strap_model.sv ====
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Board straps: mode code {write enable, pin 2, pin 1, pin 0}
module msc_strap_model (
    input  wire logic [3:0] mode_code,
    output logic            flash_write_enable_pin,
    output logic            mode_pin_2,
    output logic            mode_pin_1,
    output logic            mode_pin_0
);
    // Code changes only while reset is held, so pins never move in operation
    assign flash_write_enable_pin = mode_code[3];
    assign mode_pin_2             = mode_code[2];
    assign mode_pin_1             = mode_code[1];
    assign mode_pin_0             = mode_code[0];
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
module testbench;
    import msc_pkg::*;
    logic        mclk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0]  htrans = 2'h0;
    logic [3:0]  strap = 4'h4;
    logic        hw_standby = 1'b0, area_16bit_any = 1'b1;
    logic [23:0] cpu_addr = 24'h0;
    logic [31:0] hrdata;
    logic [3:0]  op_mode;
    logic        hreadyout, hresp, mode_pin_2, mode_pin_1, mode_pin_0;
    logic        flash_write_enable_pin, mode_valid, flash_prog_allowed;
    logic        rom_enable, external_allowed, bus_16bit, irq_ctrl_mode_hi;
    logic        irq_ctrl_mode_lo, irq_mode_prohibited, nmi_edge_select;
    logic        low_strobe_out_disable, irq_pin_route_select;
    logic        onchip_ram_enable, flash_regs_map_enable, flash_regs_selected;
    wire logic   hready;
    int          miscompares = 0, cmp_count = 0;
    // Only supported strap codes are ever applied
    localparam logic [3:0] MODES [8] = '{4'h4, 4'h5, 4'h6, 4'h7,
                                         4'hA, 4'hB, 4'hE, 4'hF};
    localparam logic [7:0] SCW [4] = '{8'h7F, 8'h20, 8'h10, 8'h04};
    localparam logic [7:0] CA [4] = '{8'hC7, 8'hC8, 8'hCB, 8'hCC};

    assign hready = hreadyout;
    always #10 mclk = ~mclk;

    msc_strap_model u_straps (.mode_code(strap), .flash_write_enable_pin,
        .mode_pin_2, .mode_pin_1, .mode_pin_0);

    msc_mode_ctrl u_dut (.mclk, .nrst, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp,
        .mode_pin_2, .mode_pin_1, .mode_pin_0, .flash_write_enable_pin,
        .hw_standby, .area_16bit_any, .cpu_addr, .op_mode, .mode_valid,
        .flash_prog_allowed, .rom_enable, .external_allowed, .bus_16bit,
        .irq_ctrl_mode_hi, .irq_ctrl_mode_lo, .irq_mode_prohibited,
        .nmi_edge_select, .low_strobe_out_disable, .irq_pin_route_select,
        .onchip_ram_enable, .flash_regs_map_enable, .flash_regs_selected);

    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Bounded wait for hready at a rising edge
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            miscompares++;
            final_report();
        end
    endtask

    task automatic bus(input logic w, input logic [15:0] idx,
                       input logic [31:0] wd, output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {14'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        r = hrdata;
        chk("hresp", 32'h0, hresp);
    endtask

    task automatic rst(input int n);
        nrst <= 1'b0;
        repeat (n) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
    endtask

    initial begin
        rst(2);
        bus(0, SYSCTL_IDX, 0, rd);
        chk("sysctl reset", 32'h01, rd);
        bus(0, FLGATE_IDX, 0, rd);
        chk("gate reset", 32'h00, rd);
        foreach (SCW[i]) begin
            bus(1, SYSCTL_IDX, SCW[i], rd);
            bus(0, SYSCTL_IDX, 0, rd);
            chk("sysctl", SCW[i] & 8'hBF, rd);
            chk("fields", SCW[i][5:0], {irq_ctrl_mode_hi, irq_ctrl_mode_lo,
                nmi_edge_select, low_strobe_out_disable,
                irq_pin_route_select, onchip_ram_enable});
            chk("irq prohibited", SCW[i][4], irq_mode_prohibited);
        end
        $display("test sysctl done");
        bus(1, FLGATE_IDX, 32'hFF, rd);
        bus(0, FLGATE_IDX, 0, rd);
        chk("gate", 32'h08, rd);
        chk("map enable", 32'h1, flash_regs_map_enable);
        foreach (CA[i]) begin
            cpu_addr <= {16'h0FFF, CA[i]};
            @(posedge mclk);
            #1;
            chk("window", CA[i] inside {[8'hC8:8'hCB]},
                flash_regs_selected);
        end
        hw_standby <= 1'b1;
        @(posedge mclk);
        hw_standby <= 1'b0;
        cpu_addr   <= 24'h0FFFC9;
        bus(0, FLGATE_IDX, 0, rd);
        chk("gate standby", 32'h00, rd);
        chk("window off", 32'h0, flash_regs_selected);
        $display("test gate done");
        bus(1, MODERB_IDX, 32'h7F, rd);
        bus(0, MODERB_IDX, 0, rd);
        chk("readback ro", 32'h84, rd);
        bus(1, 16'hFF40, 32'hFF, rd);
        bus(0, 16'hFF40, 0, rd);
        chk("unmapped", 32'h0, rd);
        $display("test access done");
        foreach (MODES[i]) begin
            strap          <= MODES[i];
            area_16bit_any <= (MODES[i] == 4'h4);
            rst(4);
            chk("op_mode", MODES[i], op_mode);
            chk("mode_valid", 32'h1, mode_valid);
            chk("flash prog", MODES[i][3], flash_prog_allowed);
            chk("rom", !(MODES[i] inside {4'h4, 4'h5}), rom_enable);
            chk("external", !(&MODES[i][1:0]), external_allowed);
            if (!(&MODES[i][1:0])) begin
                chk("bus init", MODES[i] == 4'h4, bus_16bit);
                area_16bit_any <= (MODES[i] != 4'h4);
                repeat (2) @(posedge mclk);
                #1;
                chk("bus track", MODES[i] != 4'h4, bus_16bit);
            end
            bus(0, MODERB_IDX, 0, rd);
            chk("readback", {8'h80 | MODES[i][2:0]}, rd);
        end
        $display("test modes done");
        bus(0, SYSCTL_IDX, 0, rd);
        chk("sysctl rereset", 32'h01, rd);
        final_report();
    end
endmodule
